// >>> pkg/sbg_consts.svh
// Purpose: Offsets, field positions and reset values of the serial port baud block
// Assumes: APB byte address is four times the register index
// Notes: Definitions only
`ifndef SBG_CONSTS_SVH
`define SBG_CONSTS_SVH
// ==================================================================
// Register indices and byte address width
`define SBG_IDX_RXCTL 12'h018
`define SBG_IDX_TXCTL 12'h098
`define SBG_IDX_DIV 12'h099
`define SBG_IDX_INTST 12'h100
`define SBG_IDX_INTMSK 12'h101
`define SBG_IDX_RXHOLD 12'h102
`define SBG_ADDR_W 14
// ==================================================================
// Field positions
`define SBG_RX_SPEN 7
`define SBG_RX_RX9 6
`define SBG_RX_SINGLE_RX_ENABLE 5
`define SBG_RX_CONTINUOUS_RX_ENABLE 4
`define SBG_RX_ADDR_DETECT_ENABLE 3
`define SBG_TX_CLOCK_SOURCE_SELECT 7
`define SBG_TX_SYNC 4
`define SBG_TX_HIGH_SPEED_SELECT 2
`define SBG_INT_RXLOAD 0
`define SBG_INT_OVR 1
`define SBG_INT_FRAME_ERROR_FLAG 2
// ==================================================================
// Reset values and divide ratios
`define SBG_RST_TXCTL 8'h02
`define SBG_RST_RXCTL 8'h00
`define SBG_RST_DIV 8'h00
`define SBG_PRE_ASYNC_LO 7'h40
`define SBG_PRE_ASYNC_HI 7'h10
`define SBG_PRE_SYNC 7'h04
`endif

// >>> pkg/sbg_pkg.sv
// Purpose: Types shared by the serial port baud block
// Assumes: Constants live in sbg_consts.svh
// Notes: Types only
package sbg_pkg;
  typedef enum logic [1:0] {SBG_ASYNC_LO, SBG_ASYNC_HI, SBG_SYNC_MASTER, SBG_SYNC_SLAVE} sbg_mode_t;
  typedef struct packed {
    logic [8:0] data;   // Bit 8 is the ninth bit
    logic stopBit;      // Sampled stop bit level
  } sbg_char_t;
endpackage

// >>> src/sbg_top.sv
// Purpose: Baud generator, receive status and input majority sampler of a serial port
// Assumes: clk is the core oscillator; APB slave with zero wait states
// Notes: Shift datapaths sit outside and hand over whole characters
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "sbg_consts.svh"
module sbg_top
  import sbg_pkg::*;
#(
  parameter int DIV_W = 8 // Baud timer width
) (
  input wire logic clk,                          // Core oscillator
  input wire logic rst_n,                        // Async reset, active low
  input wire logic psel,                         // APB select
  input wire logic penable,                      // APB enable
  input wire logic pwrite,                       // APB write
  input wire logic [`SBG_ADDR_W-1:0] paddr,      // APB byte address
  input wire logic [31:0] pwdata,                // APB write data
  output logic [31:0] prdata,                    // APB read data
  output logic pready,                           // APB ready
  output logic pslverr,                          // APB error, unmapped address
  input wire logic rxPin,                        // Receive / data pin
  input wire logic extClkPin,                    // Bit clock from remote master
  input wire logic rxCharValid,                  // Shift logic finished a character
  input wire sbg_char_t rxChar,                  // That character
  input wire logic txShiftEmpty,                 // Transmit shift register empty
  output logic baudTick,                         // One pulse per bit period
  output logic rxLevel,                          // Majority-voted receive level
  output logic rxEnable,                         // Reception active
  output logic irq                               // Level interrupt
);
  // ================================================================
  // Register state
  logic [7:0] rxCtl_q;
  logic [7:0] txCtl_q;
  logic [DIV_W-1:0] baudDiv_q;
  logic frameErr_q;
  logic overrun_q;
  logic ninthBit_q;
  logic [8:0] rxHold_q;
  logic holdFull_q;
  logic [2:0] intSt_q;
  logic [2:0] intMsk_q;

  function automatic logic hitIdx(input logic [`SBG_ADDR_W-1:0] a, input logic [11:0] idx);
    hitIdx = (a == {idx, 2'b00});
  endfunction
  logic setup, wrAccess, rdSetup, mapped;
  assign setup = psel && !penable;
  assign wrAccess = psel && penable && pready && pwrite;
  assign rdSetup = setup && !pwrite;
  assign mapped = hitIdx(paddr, `SBG_IDX_RXCTL) || hitIdx(paddr, `SBG_IDX_TXCTL)
               || hitIdx(paddr, `SBG_IDX_DIV) || hitIdx(paddr, `SBG_IDX_INTST)
               || hitIdx(paddr, `SBG_IDX_INTMSK) || hitIdx(paddr, `SBG_IDX_RXHOLD);

  // ================================================================
  // Mode decode
  sbg_mode_t mode;
  always_comb begin
    if (txCtl_q[`SBG_TX_SYNC]) begin
      mode = txCtl_q[`SBG_TX_CLOCK_SOURCE_SELECT] ? SBG_SYNC_MASTER : SBG_SYNC_SLAVE;
    end else begin
      mode = txCtl_q[`SBG_TX_HIGH_SPEED_SELECT] ? SBG_ASYNC_HI : SBG_ASYNC_LO;
    end
  end

  logic [6:0] preLimit;
  always_comb begin
    case (mode)
      SBG_ASYNC_LO: preLimit = `SBG_PRE_ASYNC_LO;
      SBG_ASYNC_HI: preLimit = `SBG_PRE_ASYNC_HI;
      SBG_SYNC_MASTER: preLimit = `SBG_PRE_SYNC;
      default: preLimit = `SBG_PRE_SYNC;
    endcase
  end

  // ================================================================
  // APB slave, answers in the cycle after setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= 32'h0000_0000;
      if (rdSetup) begin
        if (hitIdx(paddr, `SBG_IDX_RXCTL)) begin
          prdata[7:0] <= {rxCtl_q[7:3], frameErr_q, overrun_q, ninthBit_q};
        end
        if (hitIdx(paddr, `SBG_IDX_TXCTL)) begin
          prdata[7:0] <= {txCtl_q[7:4], 1'b0, txCtl_q[2], txShiftEmpty, txCtl_q[0]};
        end
        if (hitIdx(paddr, `SBG_IDX_DIV)) begin
          prdata[DIV_W-1:0] <= baudDiv_q;
        end
        if (hitIdx(paddr, `SBG_IDX_INTST)) begin
          prdata[2:0] <= intSt_q;
        end
        if (hitIdx(paddr, `SBG_IDX_INTMSK)) begin
          prdata[2:0] <= intMsk_q;
        end
        if (hitIdx(paddr, `SBG_IDX_RXHOLD)) begin
          prdata[7:0] <= rxHold_q[7:0];
        end
      end
    end
  end

  // ================================================================
  // Control registers
  logic wrDiv;
  assign wrDiv = wrAccess && hitIdx(paddr, `SBG_IDX_DIV);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txCtl_q <= `SBG_RST_TXCTL;
      baudDiv_q <= DIV_W'(`SBG_RST_DIV);
      intMsk_q <= 3'h0;
    end else begin
      if (wrAccess && hitIdx(paddr, `SBG_IDX_TXCTL)) begin
        txCtl_q <= {pwdata[7:4], 1'b0, pwdata[2], 1'b1, pwdata[0]};
      end
      if (wrDiv) begin
        baudDiv_q <= pwdata[DIV_W-1:0];
      end
      if (wrAccess && hitIdx(paddr, `SBG_IDX_INTMSK)) begin
        intMsk_q <= pwdata[2:0];
      end
    end
  end

  // ================================================================
  // Receive acceptance
  logic isSync, syncMaster, accept, loadChar, overEvt, readHold;
  assign isSync = txCtl_q[`SBG_TX_SYNC];
  assign syncMaster = (mode == SBG_SYNC_MASTER);
  logic rxEnable_d;
  always_comb begin
    rxEnable_d = rxCtl_q[`SBG_RX_SPEN] && (rxCtl_q[`SBG_RX_CONTINUOUS_RX_ENABLE]
                 || (syncMaster && rxCtl_q[`SBG_RX_SINGLE_RX_ENABLE]));
  end
  assign accept = rxCharValid && rxEnable_d
                  && !(rxCtl_q[`SBG_RX_RX9] && rxCtl_q[`SBG_RX_ADDR_DETECT_ENABLE] && !rxChar.data[8]);
  assign loadChar = accept && !holdFull_q;
  assign overEvt = accept && holdFull_q;
  assign readHold = rdSetup && hitIdx(paddr, `SBG_IDX_RXHOLD);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCtl_q <= `SBG_RST_RXCTL;
    end else if (wrAccess && hitIdx(paddr, `SBG_IDX_RXCTL)) begin
      rxCtl_q <= {pwdata[7:3], 3'b000};
    end else if (loadChar && isSync && !rxCtl_q[`SBG_RX_CONTINUOUS_RX_ENABLE]) begin
      rxCtl_q[`SBG_RX_SINGLE_RX_ENABLE] <= 1'b0; // Single receive ends with its character
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxHold_q <= 9'h000;
      holdFull_q <= 1'b0;
      frameErr_q <= 1'b0;
      ninthBit_q <= 1'b0;
    end else begin
      if (readHold) begin
        holdFull_q <= 1'b0;
      end
      if (loadChar) begin
        rxHold_q <= rxChar.data;
        holdFull_q <= 1'b1;
        frameErr_q <= !rxChar.stopBit;
        ninthBit_q <= rxChar.data[8];
      end
    end
  end
  // Set wins over the clear done by dropping continuous receive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (overEvt) begin
      overrun_q <= 1'b1;
    end else if (!rxCtl_q[`SBG_RX_CONTINUOUS_RX_ENABLE]) begin
      overrun_q <= 1'b0;
    end
  end

  // ================================================================
  // Interrupt status, write one to clear, set wins
  logic [2:0] intEvt, intClr;
  assign intEvt = {loadChar && !rxChar.stopBit, overEvt, loadChar};
  assign intClr = (wrAccess && hitIdx(paddr, `SBG_IDX_INTST)) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intSt_q <= 3'h0;
      irq <= 1'b0;
      rxEnable <= 1'b0;
    end else begin
      intSt_q <= (intSt_q & ~intClr) | intEvt;
      irq <= |(intSt_q & intMsk_q);
      rxEnable <= rxEnable_d;
    end
  end

  // ================================================================
  // Baud generator: prescaler then 8-bit reload timer
  logic [6:0] pre_q;
  logic [DIV_W-1:0] baudCnt_q;
  logic preWrap, cntWrap;
  assign preWrap = (pre_q == preLimit - 7'd1);
  assign cntWrap = (baudCnt_q == baudDiv_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 7'h00;
      baudCnt_q <= '0;
    end else if (wrDiv) begin
      pre_q <= 7'h00;
      baudCnt_q <= '0;
    end else if (preWrap || pre_q >= preLimit) begin
      pre_q <= 7'h00;
      baudCnt_q <= cntWrap ? '0 : baudCnt_q + DIV_W'(1);
    end else begin
      pre_q <= pre_q + 7'd1;
    end
  end

  // ================================================================
  // Pin synchronisers; a change counts once stages two and three agree
  logic [2:0] rxSync_q, clkSync_q;
  logic [2:0] rxHist_q;
  logic extClkLvl_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSync_q <= 3'b111;
      clkSync_q <= 3'b000;
      rxHist_q <= 3'b111;
      extClkLvl_q <= 1'b0;
      rxLevel <= 1'b1;
    end else begin
      rxSync_q <= {rxSync_q[1:0], rxPin};
      clkSync_q <= {clkSync_q[1:0], extClkPin};
      if (rxSync_q[1] == rxSync_q[2]) begin
        rxHist_q <= {rxHist_q[1:0], rxSync_q[2]};
      end
      rxLevel <= (rxHist_q[0] & rxHist_q[1]) | (rxHist_q[1] & rxHist_q[2])
                 | (rxHist_q[0] & rxHist_q[2]);
      if (clkSync_q[1] == clkSync_q[2]) begin
        extClkLvl_q <= clkSync_q[2];
      end
    end
  end
  // Slave bit clock comes from the remote master, not the timer
  logic extRise;
  assign extRise = (clkSync_q[1] == clkSync_q[2]) && clkSync_q[2] && !extClkLvl_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudTick <= 1'b0;
    end else if (mode == SBG_SYNC_SLAVE) begin
      baudTick <= extRise;
    end else begin
      baudTick <= !wrDiv && preWrap && cntWrap;
    end
  end
  // ================================================================
  // Checks
  logic [16:0] tickGap_q;
  logic gapOk_q;
  // First tick after a rate or mode change is exempt from the period check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickGap_q <= '0;
      gapOk_q <= 1'b0;
    end else begin
      tickGap_q <= (baudTick || wrDiv || mode == SBG_SYNC_SLAVE) ? '0 : tickGap_q + 17'd1;
      gapOk_q <= (gapOk_q || baudTick) && !wrDiv && mode != SBG_SYNC_SLAVE
                 && !(wrAccess && hitIdx(paddr, `SBG_IDX_TXCTL));
    end
  end
  divider_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    baudCnt_q <= baudDiv_q)
    else $error("baud timer passed divisor");
  rate_formula_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode != SBG_SYNC_SLAVE && baudTick && gapOk_q
    |-> tickGap_q + 17'd1 == 17'(preLimit) * 17'(baudDiv_q + 9'd1))
    else $error("baud period differs from formula");
  div_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrDiv && mode != SBG_SYNC_SLAVE |=> (pre_q == 7'h00 && baudCnt_q == '0 && !baudTick))
    else $error("divisor write did not clear timer");
  sync_ratio_a: assert property (@(posedge clk) disable iff (!rst_n)
    isSync && txCtl_q[`SBG_TX_CLOCK_SOURCE_SELECT] |-> preLimit == `SBG_PRE_SYNC)
    else $error("sync mode used speed select");
  async_ratio_a: assert property (@(posedge clk) disable iff (!rst_n)
    !isSync |-> preLimit == (txCtl_q[`SBG_TX_HIGH_SPEED_SELECT] ? `SBG_PRE_ASYNC_HI : `SBG_PRE_ASYNC_LO))
    else $error("async ratio wrong");
  addr_detect_a: assert property (@(posedge clk) disable iff (!rst_n)
    rxCharValid && rxCtl_q[`SBG_RX_RX9] && rxCtl_q[`SBG_RX_ADDR_DETECT_ENABLE] && !rxChar.data[8]
    |=> $stable(rxHold_q) && !intSt_q[`SBG_INT_RXLOAD] || $past(intSt_q[0]))
    else $error("address detect loaded a data character");
  overrun_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    overEvt |=> overrun_q ##1 (overrun_q || !$past(rxCtl_q[`SBG_RX_CONTINUOUS_RX_ENABLE])))
    else $error("overrun flag lost");
  frame_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    loadChar |=> frameErr_q == !$past(rxChar.stopBit))
    else $error("frame error flag wrong");
  majority_a: assert property (@(posedge clk) disable iff (!rst_n)
    rxHist_q == 3'b111 |=> rxLevel)
    else $error("majority vote wrong");
  cont_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
    rxCtl_q[`SBG_RX_SPEN] && rxCtl_q[`SBG_RX_CONTINUOUS_RX_ENABLE] |=> rxEnable)
    else $error("continuous receive not enabled");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(intSt_q & intMsk_q) |=> irq)
    else $error("interrupt not raised");
  tick_lo_c: cover property (@(posedge clk) disable iff (!rst_n)
    baudTick && mode == SBG_ASYNC_LO);
  tick_sync_c: cover property (@(posedge clk) disable iff (!rst_n)
    baudTick && mode == SBG_SYNC_MASTER);
  overrun_c: cover property (@(posedge clk) disable iff (!rst_n) overEvt);
  div_write_c: cover property (@(posedge clk) disable iff (!rst_n) wrDiv ##[1:200] baudTick);
endmodule

// >>> sim/sbg_remote.sv
// Purpose: Remote serial device model facing the receive side of the block
// Assumes: Characters arrive already deserialised by the shift logic
// Notes: Released character lines show inverted old data; bit clock idles low
`timescale 1ns/100ps
module sbg_remote
  import sbg_pkg::*;
(
  input wire logic clk,      // Core clock
  output logic rxPin,        // Receive line level
  output logic extClkPin,    // Bit clock as remote master
  output logic rxCharValid,  // Character strobe
  output sbg_char_t rxChar,  // Character with stop level
  output logic txShiftEmpty  // Transmit shift register empty
);
  initial begin
    rxPin = 1'b1;
    extClkPin = 1'b0;
    rxCharValid = 1'b0;
    rxChar = '0;
    txShiftEmpty = 1'b1;
  end
  // ==================================================================
  // Stimulus tasks, entered just after a rising edge
  task automatic sendChar(input logic [8:0] d, input logic s);
    rxCharValid <= 1'b1;
    rxChar <= '{data: d, stopBit: s};
    @(posedge clk);
    rxCharValid <= 1'b0;
    rxChar <= ~{d, s};
  endtask
  task automatic line(input logic v, input int c);
    rxPin <= v;
    repeat (c) @(posedge clk);
  endtask
  task automatic bitClk();
    extClkPin <= 1'b1;
    repeat (4) @(posedge clk);
    extClkPin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> sim/serial_port_baud_generator_tb.sv
// Purpose: Self-checking bench for the serial port baud block
// Assumes: One-cycle APB answer, registers at four times their index
// Notes: Baud periods kept short; divisor 8'hFF only with the 16 and 4 prescaler ratios
`timescale 1ns/100ps
module serial_port_baud_generator_tb;
  import sbg_pkg::*;
  localparam logic [13:0] RXC = 14'h0060;
  localparam logic [13:0] TXC = 14'h0260;
  localparam logic [13:0] DIV = 14'h0264;
  localparam logic [13:0] IST = 14'h0400;
  localparam logic [13:0] IMK = 14'h0404;
  localparam logic [13:0] RXH = 14'h0408;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv, baudTick, rxLevel, rxEnable, irq;
  logic rxPin, extClkPin, rxCharValid, txShiftEmpty, seenLow;
  sbg_char_t rxChar;
  int error_cnt = 0;
  int tests_run = 0;
  int k;
  int t;
  always #12.5 clk = ~clk;
  sbg_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxPin(rxPin), .extClkPin(extClkPin), .rxCharValid(rxCharValid), .rxChar(rxChar),
    .txShiftEmpty(txShiftEmpty), .baudTick(baudTick), .rxLevel(rxLevel),
    .rxEnable(rxEnable), .irq(irq));
  sbg_remote peer_u (.clk(clk), .rxPin(rxPin), .extClkPin(extClkPin),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .txShiftEmpty(txShiftEmpty));
  // ==================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Idle cycle at the end keeps psel from being driven twice in one step
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [13:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic waitTick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (baudTick !== 1'b1 && n < 20000);
  endtask
  task automatic gap(input logic [31:0] txc, input logic [7:0] x, input int p);
    xfer(1'b1, TXC, txc);
    xfer(1'b1, DIV, {24'h00_0000, x});
    waitTick(k);
    waitTick(k);
    check(k, p * (x + 1));
  endtask
  task automatic chr(input logic [8:0] d, input logic s);
    peer_u.sendChar(d, s);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  // ==================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(RXC, 32'h0000_0000);
    rdChk(TXC, 32'h0000_0002);
    rdChk(DIV, 32'h0000_0000);
    rdChk(IMK, 32'h0000_0000);
    rdChk(14'h0700, 32'h0000_0000);
    check(slv, 1'b1);
    // Majority vote: one-cycle glitch filtered, held level passes
    seenLow = 1'b0;
    peer_u.line(1'b0, 1);
    peer_u.line(1'b1, 0);
    for (t = 0; t < 10; t++) begin
      @(posedge clk);
      if (rxLevel !== 1'b1) seenLow = 1'b1;
    end
    check(seenLow, 1'b0);
    peer_u.line(1'b0, 10);
    check(rxLevel, 1'b0);
    peer_u.line(1'b1, 10);
    // Receive status, interrupt and overrun
    xfer(1'b1, IMK, 32'h0000_0007);
    xfer(1'b1, RXC, 32'h0000_0090);
    chr(9'h1A5, 1'b1);
    check(irq, 1'b1);
    rdChk(RXC, 32'h0000_0091);
    chr(9'h033, 1'b1);
    rdChk(IST, 32'h0000_0003);
    rdChk(RXC, 32'h0000_0093);
    xfer(1'b1, RXC, 32'h0000_0080);
    rdChk(RXC, 32'h0000_0081);
    rdChk(RXH, 32'h0000_00A5);
    xfer(1'b1, IST, 32'h0000_0007);
    rdChk(IST, 32'h0000_0000);
    check(irq, 1'b0);
    // Frame error follows each loaded character
    xfer(1'b1, RXC, 32'h0000_0090);
    chr(9'h044, 1'b0);
    rdChk(RXC, 32'h0000_0094);
    rdChk(IST, 32'h0000_0005);
    rdChk(RXH, 32'h0000_0044);
    xfer(1'b1, IST, 32'h0000_0007);
    xfer(1'b1, IMK, 32'h0000_0000);
    chr(9'h011, 1'b1);
    check(irq, 1'b0);
    rdChk(RXC, 32'h0000_0090);
    rdChk(RXH, 32'h0000_0011);
    xfer(1'b1, IST, 32'h0000_0007);
    // Address detect with nine-bit reception
    xfer(1'b1, RXC, 32'h0000_00D8);
    chr(9'h022, 1'b1);
    rdChk(IST, 32'h0000_0000);
    chr(9'h122, 1'b1);
    rdChk(IST, 32'h0000_0001);
    rdChk(RXH, 32'h0000_0022);
    xfer(1'b1, IST, 32'h0000_0007);
    // Synchronous master: continuous overrides single receive
    xfer(1'b1, TXC, 32'h0000_0090);
    xfer(1'b1, RXC, 32'h0000_00B0);
    chr(9'h055, 1'b1);
    check(rxEnable, 1'b1);
    rdChk(RXC, 32'h0000_00B0);
    rdChk(RXH, 32'h0000_0055);
    xfer(1'b1, RXC, 32'h0000_00A0);
    check(rxEnable, 1'b1);
    chr(9'h066, 1'b1);
    check(rxEnable, 1'b0);
    rdChk(RXC, 32'h0000_0080);
    // Baud periods in both asynchronous modes and synchronous master
    gap(32'h0000_0000, 8'h02, 64);
    gap(32'h0000_0004, 8'h02, 16);
    gap(32'h0000_0004, 8'hFF, 16);
    gap(32'h0000_0090, 8'h03, 4);
    gap(32'h0000_0094, 8'h00, 4);
    gap(32'h0000_0090, 8'hFF, 4);
    // New divisor restarts the timer at once
    xfer(1'b1, DIV, 32'h0000_00C8);
    repeat (300) @(posedge clk);
    xfer(1'b1, DIV, 32'h0000_0001);
    waitTick(k);
    check(k, 8);
    // Slave: ticks only follow the remote bit clock
    xfer(1'b1, TXC, 32'h0000_0010);
    repeat (20) @(posedge clk);
    t = 0;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (baudTick === 1'b1) t++;
    end
    check(t, 0);
    fork
      peer_u.bitClk();
      waitTick(k);
    join
    check(k < 10, 1'b1);
    wrap_up();
  end
endmodule
